// ===== hdl/codec_regs_pkg.sv
// Constants for the codec gain, volume and soft-mute register slice.
// What this block does
// R1: The input-method bit selects differential ADC input at 0 (reset) and single-ended or pseudo-differential at 1.
// R2: Both converters stay in reset while the converter reset bit is 0 and run once it is set to 1.
// R3: The input gain register reads zero in its top four bits and holds a four-bit gain code resetting to 0010.
// R4: An eight-bit ADC volume code resets to 0x30 and scales the ADC output samples.
// R5: An eight-bit DAC volume code resets to 0x18 and scales the incoming DAC samples.
// R6: Writing 1 to the ADC mute bit starts the ADC soft mute and 0 releases it.
// R7: The ADC mute transition lasts 4 sample periods with its speed bit at 0 and 16 with it at 1.
// R8: Writing 1 to the DAC mute bit starts the DAC soft mute and 0 releases it.
// R9: The DAC mute transition lasts 4 sample periods with its speed bit at 0 and 16 with it at 1.
// R10: DAC samples are two's complement, 0x800000 negative full scale, zero midscale, 0x7FFFFF positive full scale.
// R11: ADC output samples are two's complement with their DC offset removed by a high-pass filter.
// R12: The analog input is oversampled at 64 times the sample rate before decimation.
// R13: Every control register returns to its default while the power-down pin is low.
// R14: Software never writes 1 into a bit that is fixed at zero.
// R15: The register address advances after each byte of a burst and wraps from the last address to 0x00.
// R16: A soft mute ramps the effective volume smoothly down to full attenuation and back up on release.
package codec_regs_pkg;
    localparam logic [3:0] ADDR_POWER = 4'h4;
    localparam logic [3:0] ADDR_GAIN = 4'h5;
    localparam logic [3:0] ADDR_ADC_VOL = 4'h6;
    localparam logic [3:0] ADDR_DAC_VOL = 4'h7;
    localparam logic [3:0] ADDR_MUTE = 4'h8;
    localparam logic [3:0] ADDR_LAST = 4'h9;
    localparam int BIT_INPUT_METHOD = 2;
    localparam int BIT_CONV_RESET = 0;
    localparam int BIT_ADC_MUTE = 5;
    localparam int BIT_ADC_SPEED = 4;
    localparam int BIT_DAC_MUTE = 1;
    localparam int BIT_DAC_SPEED = 0;
    localparam logic [7:0] POWER_MASK = 8'h05;
    localparam logic [7:0] GAIN_MASK = 8'h0F;
    localparam logic [7:0] MUTE_MASK = 8'h33;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [3:0] RST_GAIN = 4'h2;
    localparam logic [7:0] RST_ADC_VOL = 8'h30;
    localparam logic [7:0] RST_DAC_VOL = 8'h18;
    localparam logic [7:0] RST_MUTE = 8'h00;
    localparam int FAST_PERIODS = 4;
    localparam int SLOW_PERIODS = 16;
    localparam int OVERSAMPLE = 64;
    localparam logic [23:0] NEG_FULL = 24'h800000;
    localparam logic [23:0] POS_FULL = 24'h7FFFFF;
    localparam int HPF_SHIFT = 10;
    typedef enum logic [1:0] {
        MUTE_IDLE = 2'b00,
        MUTE_DOWN = 2'b01,
        MUTE_HELD = 2'b10,
        MUTE_UP = 2'b11
    } mute_state_type;
endpackage

// ===== hdl/codec_regs.sv
// Gain, volume and soft-mute control registers with the sample paths they steer.
`timescale 1ns/1ps
module codec_regs #(
    parameter int SAMPLE_W = 24
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic POWER_DOWN_N_PIN_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic START_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic FS_TICK_IN,
    input wire logic OS_TICK_IN,
    input wire logic signed [SAMPLE_W-1:0] ADC_RAW_IN,
    input wire logic signed [SAMPLE_W-1:0] DAC_SAMPLE_IN,
    output logic [7:0] RDATA_OUT,
    output logic [3:0] ADDR_PTR_OUT,
    output logic ADC_INPUT_METHOD_SEL_OUT,
    output logic CONVERTER_RESET_N_OUT,
    output logic [3:0] MIC_GAIN_CODE_OUT,
    output logic ADC_MUTED_OUT,
    output logic DAC_MUTED_OUT,
    output logic DEC_STROBE_OUT,
    output logic signed [SAMPLE_W-1:0] ADC_SAMPLE_OUT,
    output logic signed [SAMPLE_W-1:0] DAC_OUT
);
    // ----------------------------------------------------------------
    // Pin synchroniser and register bank
    // ----------------------------------------------------------------
    logic pdn_meta;
    logic pdn_sync;
    logic [7:0] power_reg;
    logic [3:0] mic_gain_code;
    logic [7:0] adc_volume_code;
    logic [7:0] dac_volume_code;
    logic [7:0] mute_reg;
    logic [3:0] addr_ptr;
    logic clear_regs;

    // The pin is asynchronous, so it passes two flops; the registers stay cleared two cycles past its release.
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            pdn_meta <= 1'b0;
            pdn_sync <= 1'b0;
        end else begin
            pdn_meta <= POWER_DOWN_N_PIN_IN;
            pdn_sync <= pdn_meta;
        end
    end

    assign clear_regs = RST_IN || !pdn_sync;

    // The transfer engine presents each byte with START for the first byte of a burst.
    logic [3:0] acc_addr;
    assign acc_addr = START_IN ? ADDR_IN : addr_ptr;

    always_ff @(posedge CLK_IN) begin
        if (clear_regs) begin
            power_reg <= codec_regs_pkg::RST_POWER; // R13
            mic_gain_code <= codec_regs_pkg::RST_GAIN; // R3
            adc_volume_code <= codec_regs_pkg::RST_ADC_VOL; // R4
            dac_volume_code <= codec_regs_pkg::RST_DAC_VOL; // R5
            mute_reg <= codec_regs_pkg::RST_MUTE;
        end else if (WR_IN) begin
            // Fixed-zero bits are masked so a stray 1 cannot stick.
            case (acc_addr)
                codec_regs_pkg::ADDR_POWER: power_reg <= WDATA_IN & codec_regs_pkg::POWER_MASK;
                codec_regs_pkg::ADDR_GAIN: mic_gain_code <= WDATA_IN[3:0]; // R3
                codec_regs_pkg::ADDR_ADC_VOL: adc_volume_code <= WDATA_IN; // R4
                codec_regs_pkg::ADDR_DAC_VOL: dac_volume_code <= WDATA_IN; // R5
                codec_regs_pkg::ADDR_MUTE: mute_reg <= WDATA_IN & codec_regs_pkg::MUTE_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (clear_regs) begin
            addr_ptr <= 4'h0;
        end else if (WR_IN || RD_IN) begin
            addr_ptr <= (acc_addr == codec_regs_pkg::ADDR_LAST) ? 4'h0 : acc_addr + 4'h1; // R15
        end else if (START_IN) begin
            addr_ptr <= ADDR_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (clear_regs) begin
            RDATA_OUT <= 8'h00;
        end else if (RD_IN) begin
            case (acc_addr)
                codec_regs_pkg::ADDR_POWER: RDATA_OUT <= power_reg;
                codec_regs_pkg::ADDR_GAIN: RDATA_OUT <= {4'h0, mic_gain_code}; // R3
                codec_regs_pkg::ADDR_ADC_VOL: RDATA_OUT <= adc_volume_code;
                codec_regs_pkg::ADDR_DAC_VOL: RDATA_OUT <= dac_volume_code;
                codec_regs_pkg::ADDR_MUTE: RDATA_OUT <= mute_reg;
                default: RDATA_OUT <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (clear_regs) begin
            ADDR_PTR_OUT <= 4'h0;
            ADC_INPUT_METHOD_SEL_OUT <= 1'b0;
            CONVERTER_RESET_N_OUT <= 1'b0;
            MIC_GAIN_CODE_OUT <= codec_regs_pkg::RST_GAIN;
        end else begin
            ADDR_PTR_OUT <= addr_ptr;
            ADC_INPUT_METHOD_SEL_OUT <= power_reg[codec_regs_pkg::BIT_INPUT_METHOD]; // R1
            CONVERTER_RESET_N_OUT <= power_reg[codec_regs_pkg::BIT_CONV_RESET]; // R2
            MIC_GAIN_CODE_OUT <= mic_gain_code;
        end
    end

    logic conv_run;
    assign conv_run = power_reg[codec_regs_pkg::BIT_CONV_RESET] && !clear_regs;

    // ----------------------------------------------------------------
    // Oversampling decimation strobe
    // ----------------------------------------------------------------
    logic [5:0] os_count;
    always_ff @(posedge CLK_IN) begin
        if (!conv_run) begin
            os_count <= 6'h00;
            DEC_STROBE_OUT <= 1'b0;
        end else begin
            DEC_STROBE_OUT <= 1'b0;
            if (OS_TICK_IN) begin
                os_count <= os_count + 6'h01;
                DEC_STROBE_OUT <= (os_count == 6'(codec_regs_pkg::OVERSAMPLE - 1)); // R12
            end
        end
    end

    // ----------------------------------------------------------------
    // Soft mute ramps
    // ----------------------------------------------------------------
    logic [4:0] adc_gain;
    logic [4:0] dac_gain;
    logic [4:0] adc_step;
    logic [4:0] dac_step;
    mute_ramp adc_ramp (
        .clk_in(CLK_IN),
        .clear_in(!conv_run),
        .tick_in(FS_TICK_IN),
        .mute_in(mute_reg[codec_regs_pkg::BIT_ADC_MUTE]),
        .slow_in(mute_reg[codec_regs_pkg::BIT_ADC_SPEED]),
        .gain_out(adc_gain),
        .step_out(adc_step)
    ); // R6 R7
    mute_ramp dac_ramp (
        .clk_in(CLK_IN),
        .clear_in(!conv_run),
        .tick_in(FS_TICK_IN),
        .mute_in(mute_reg[codec_regs_pkg::BIT_DAC_MUTE]),
        .slow_in(mute_reg[codec_regs_pkg::BIT_DAC_SPEED]),
        .gain_out(dac_gain),
        .step_out(dac_step)
    ); // R8 R9

    // ----------------------------------------------------------------
    // Sample paths
    // ----------------------------------------------------------------
    // Volume code scales linearly around unity at the reset code; this is a coarse gain, not a dB law.
    function automatic logic signed [SAMPLE_W-1:0] scale(input logic signed [SAMPLE_W-1:0] s,
            input logic [7:0] vol, input logic [7:0] unity, input logic [4:0] g);
        logic signed [SAMPLE_W+14:0] p;
        logic signed [SAMPLE_W+14:0] q;
        p = (SAMPLE_W+15)'(s) * $signed({1'b0, vol}) * $signed({1'b0, g});
        q = p / $signed({1'b0, unity, 4'h0});
        if (q > $signed((SAMPLE_W+15)'(codec_regs_pkg::POS_FULL))) begin
            scale = codec_regs_pkg::POS_FULL;
        end else if (q < -$signed((SAMPLE_W+15)'(codec_regs_pkg::POS_FULL)) - 1) begin
            scale = codec_regs_pkg::NEG_FULL; // R10
        end else begin
            scale = q[SAMPLE_W-1:0];
        end
    endfunction

    logic signed [SAMPLE_W+9:0] dc_est;
    logic signed [SAMPLE_W-1:0] hpf_out;
    assign hpf_out = ADC_RAW_IN - dc_est[SAMPLE_W+9:10];

    always_ff @(posedge CLK_IN) begin
        if (!conv_run) begin
            dc_est <= '0;
            ADC_SAMPLE_OUT <= '0;
            DAC_OUT <= '0;
        end else if (FS_TICK_IN) begin
            dc_est <= dc_est + (SAMPLE_W+10)'(hpf_out); // R11
            ADC_SAMPLE_OUT <= scale(hpf_out, adc_volume_code, codec_regs_pkg::RST_ADC_VOL, adc_gain); // R4 R11
            DAC_OUT <= scale(DAC_SAMPLE_IN, dac_volume_code, codec_regs_pkg::RST_DAC_VOL, dac_gain); // R5 R10
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!conv_run) begin
            ADC_MUTED_OUT <= 1'b0;
            DAC_MUTED_OUT <= 1'b0;
        end else begin
            ADC_MUTED_OUT <= (adc_gain == 5'h00);
            DAC_MUTED_OUT <= (dac_gain == 5'h00);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // These watch the block's internal state and several of its output ports; the bench judges what reaches the pins.
    a_gain_reset: assert property (@(posedge CLK_IN) $rose(clear_regs) |=> mic_gain_code == 4'h2 // R13
        && adc_volume_code == 8'h30 && dac_volume_code == 8'h18 && mute_reg == 8'h00)
        else $error("Registers not at defaults after clear.");
    a_gain_upper_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R3
        $past(RD_IN) && $past(acc_addr) == 4'h5 |-> RDATA_OUT[7:4] == 4'h0)
        else $error("Gain upper bits not zero.");
    a_addr_wrap: assert property (@(posedge CLK_IN) disable iff (clear_regs) // R15
        (WR_IN || RD_IN) && acc_addr == 4'h9 |=> addr_ptr == 4'h0)
        else $error("Address did not wrap.");
    a_addr_incr: assert property (@(posedge CLK_IN) disable iff (clear_regs) // R15
        (WR_IN || RD_IN) && acc_addr < 4'h9 |=> addr_ptr == $past(acc_addr) + 4'h1)
        else $error("Address did not advance.");
    a_conv_reset: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R2
        !power_reg[0] |=> !CONVERTER_RESET_N_OUT && DAC_OUT == 0)
        else $error("Converters not held in reset.");
    a_input_method: assert property (@(posedge CLK_IN) disable iff (clear_regs) // R1
        WR_IN && acc_addr == 4'h4 |=> ##1 ADC_INPUT_METHOD_SEL_OUT == $past(WDATA_IN[2], 2))
        else $error("Input method not applied.");
    a_adc_vol_write: assert property (@(posedge CLK_IN) disable iff (clear_regs) // R4
        WR_IN && acc_addr == 4'h6 |=> adc_volume_code == $past(WDATA_IN))
        else $error("ADC volume not stored.");
    a_dac_vol_write: assert property (@(posedge CLK_IN) disable iff (clear_regs) // R5
        WR_IN && acc_addr == 4'h7 |=> dac_volume_code == $past(WDATA_IN))
        else $error("DAC volume not stored.");
    a_adc_mute_fast: assert property (@(posedge CLK_IN) disable iff (!conv_run) // R6 R7
        adc_gain == 5'h10 && mute_reg[5] && !mute_reg[4] |-> adc_step == 5'h04)
        else $error("ADC fast step wrong.");
    a_dac_mute_slow: assert property (@(posedge CLK_IN) disable iff (!conv_run) // R8 R9
        dac_gain == 5'h10 && mute_reg[1] && mute_reg[0] |-> dac_step == 5'h01)
        else $error("DAC slow step wrong.");
    a_ramp_smooth: assert property (@(posedge CLK_IN) disable iff (!conv_run) // R16
        FS_TICK_IN |=> (adc_gain >= $past(adc_gain) ? adc_gain - $past(adc_gain)
        : $past(adc_gain) - adc_gain) <= 5'h04)
        else $error("Mute ramp jumped.");
    a_mic_gain_out: assert property (@(posedge CLK_IN) disable iff (clear_regs) // R3
        WR_IN && acc_addr == 4'h5 |=> ##1 MIC_GAIN_CODE_OUT == $past(WDATA_IN[3:0], 2))
        else $error("Gain code not applied.");
    a_mute_write: assert property (@(posedge CLK_IN) disable iff (clear_regs) // R6 R8
        WR_IN && acc_addr == 4'h8 |=> mute_reg == ($past(WDATA_IN) & 8'h33))
        else $error("Mute control not stored.");
    a_strobe_count: assert property (@(posedge CLK_IN) // R12
        conv_run && OS_TICK_IN && os_count == 6'h3F |=> DEC_STROBE_OUT)
        else $error("Decimation strobe missing.");
    a_conv_hold: assert property (@(posedge CLK_IN) // R2
        !conv_run |=> ADC_SAMPLE_OUT == 0 && !ADC_MUTED_OUT && !DEC_STROBE_OUT)
        else $error("Converter outputs not held.");
    a_pin_clear: assert property (@(posedge CLK_IN) // R13
        !pdn_sync |=> power_reg == 8'h00 && addr_ptr == 4'h0 && RDATA_OUT == 8'h00)
        else $error("Pin did not clear registers.");
    a_adc_mute_fall: assert property (@(posedge CLK_IN) disable iff (!conv_run) // R6
        FS_TICK_IN && mute_reg[5] && adc_gain != 5'h00 |=> adc_gain < $past(adc_gain))
        else $error("ADC mute not ramping down.");
    a_adc_release: assert property (@(posedge CLK_IN) disable iff (!conv_run) // R6
        FS_TICK_IN && !mute_reg[5] && adc_gain != 5'h10 |=> adc_gain > $past(adc_gain))
        else $error("ADC mute not releasing.");
    a_dac_mute_fall: assert property (@(posedge CLK_IN) disable iff (!conv_run) // R8
        FS_TICK_IN && mute_reg[1] && dac_gain != 5'h00 |=> dac_gain < $past(dac_gain))
        else $error("DAC mute not ramping down.");
    a_dac_release: assert property (@(posedge CLK_IN) disable iff (!conv_run) // R8
        FS_TICK_IN && !mute_reg[1] && dac_gain != 5'h10 |=> dac_gain > $past(dac_gain))
        else $error("DAC mute not releasing.");
    c_burst_wrap: cover property (@(posedge CLK_IN) WR_IN && acc_addr == 4'h9 ##1 WR_IN);
    c_adc_muted: cover property (@(posedge CLK_IN) $rose(ADC_MUTED_OUT));
    c_dac_unmute: cover property (@(posedge CLK_IN) $fell(DAC_MUTED_OUT));
    c_pin_clear: cover property (@(posedge CLK_IN) $fell(pdn_sync));
    c_slow_ramp: cover property (@(posedge CLK_IN) FS_TICK_IN && mute_reg[4] && adc_gain == 5'h01);
endmodule

// Gain ramp from 16 (unity) to 0 in 4 or 16 sample periods.
module mute_ramp (
    input wire logic clk_in,
    input wire logic clear_in,
    input wire logic tick_in,
    input wire logic mute_in,
    input wire logic slow_in,
    output logic [4:0] gain_out,
    output logic [4:0] step_out
);
    // Sixteen gain steps split evenly over the transition, so both speeds land exactly on zero.
    assign step_out = slow_in ? 5'(16 / codec_regs_pkg::SLOW_PERIODS) : 5'(16 / codec_regs_pkg::FAST_PERIODS);
    always_ff @(posedge clk_in) begin
        if (clear_in) begin
            gain_out <= 5'h10;
        end else if (tick_in) begin
            // A speed change mid-ramp takes effect on the next period.
            if (mute_in) begin
                gain_out <= (gain_out > step_out) ? gain_out - step_out : 5'h00; // R16
            end else begin
                gain_out <= (gain_out + step_out < 5'h10) ? gain_out + step_out : 5'h10; // R16
            end
        end
    end
endmodule

// ===== verification/host_model.sv
// Register host model that hands byte accesses to the block as the bus engine does.
`timescale 1ns/1ps
module host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic wr_out,
    output logic rd_out,
    output logic start_out,
    output logic [3:0] addr_out,
    output logic [7:0] wdata_out
);
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        start_out = 1'b0;
        addr_out = 4'hF;
        wdata_out = 8'hA5;
    end
    // The address and data lines carry junk outside a request so a stale value cannot pass.
    task automatic xfer(input logic st, input logic [3:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk_in);
        start_out = st;
        addr_out = a;
        wr_out = w;
        rd_out = !w;
        wdata_out = d;
        @(negedge clk_in);
        start_out = 1'b0;
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
        @(negedge clk_in);
        q = rdata_in;
    endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the gain, volume and soft-mute register slice.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pdn_n = 1'b1;
    logic fs = 1'b0;
    logic os = 1'b0;
    logic signed [23:0] adc_raw = 24'h000000;
    logic signed [23:0] dac_in = 24'h000000;
    logic wr, rd, st;
    logic [3:0] addr, ptr, gain;
    logic [7:0] wdata, rdata, q;
    logic ims, crn, amute, dmute, strobe;
    logic signed [23:0] adc_out, dac_out;
    int miscompares = 0;
    int n_tests = 0;
    always #12.5 clk = ~clk;
    codec_regs codec_regs_inst (.CLK_IN(clk), .RST_IN(rst), .POWER_DOWN_N_PIN_IN(pdn_n), .WR_IN(wr),
        .RD_IN(rd), .START_IN(st), .ADDR_IN(addr), .WDATA_IN(wdata), .FS_TICK_IN(fs), .OS_TICK_IN(os),
        .ADC_RAW_IN(adc_raw), .DAC_SAMPLE_IN(dac_in), .RDATA_OUT(rdata), .ADDR_PTR_OUT(ptr),
        .ADC_INPUT_METHOD_SEL_OUT(ims), .CONVERTER_RESET_N_OUT(crn), .MIC_GAIN_CODE_OUT(gain),
        .ADC_MUTED_OUT(amute), .DAC_MUTED_OUT(dmute), .DEC_STROBE_OUT(strobe), .ADC_SAMPLE_OUT(adc_out),
        .DAC_OUT(dac_out));
    host_model host_model_inst (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .start_out(st),
        .addr_out(addr), .wdata_out(wdata));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk);
            fs = 1'b1;
            @(negedge clk);
            fs = 1'b0;
            repeat (8) @(negedge clk);
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic defaults_burst();
        logic [7:0] exp [4] = '{8'h02, 8'h30, 8'h18, 8'h00};
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_POWER, 1'b0, 8'h00, q);
        chk(q, 8'h00);
        for (int i = 0; i < 4; i++) begin
            host_model_inst.xfer(1'b0, 4'h0, 1'b0, 8'h00, q);
            chk(q, exp[i]);
        end
        chk({ims, crn, gain}, 6'h02);
    endtask
    task automatic write_burst();
        logic [7:0] wv [5] = '{8'h05, 8'h0D, 8'hA7, 8'h5C, 8'h00};
        for (int i = 0; i < 5; i++) host_model_inst.xfer(i == 0, codec_regs_pkg::ADDR_POWER, 1'b1, wv[i], q);
        for (int i = 0; i < 5; i++) begin
            host_model_inst.xfer(i == 0, codec_regs_pkg::ADDR_POWER, 1'b0, 8'h00, q);
            chk(q, wv[i]);
        end
        chk({ims, crn, gain}, 6'h3D);
    endtask
    task automatic wrap_read();
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_LAST, 1'b0, 8'h00, q);
        chk(q, 8'h00);
        host_model_inst.xfer(1'b0, 4'h0, 1'b0, 8'h00, q);
        chk(q, 8'h00);
        chk(ptr, 4'h1);
    endtask
    task automatic mute_case(input logic [7:0] val, input int n, input logic adc);
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_MUTE, 1'b1, val, q);
        ticks(n - 1);
        chk(adc ? amute : dmute, 1'b0);
        ticks(1);
        chk(adc ? amute : dmute, 1'b1);
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_MUTE, 1'b1, 8'h00, q);
        ticks(1);
        chk(adc ? amute : dmute, 1'b0);
        // Let the ramp climb three more periods; the release write clears the speed bit, so every case climbs at the fast speed back to unity.
        ticks(3);
    endtask
    task automatic sample_codes();
        int seen;
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_ADC_VOL, 1'b1, 8'h30, q);
        host_model_inst.xfer(1'b0, 4'h0, 1'b1, 8'h18, q);
        dac_in = codec_regs_pkg::NEG_FULL;
        adc_raw = -24'sd4096;
        ticks(1);
        chk(dac_out, 24'h800000);
        chk(adc_out[23], 1'b1);
        seen = 0;
        repeat (128) begin
            @(negedge clk);
            os = 1'b1;
            @(negedge clk);
            os = 1'b0;
            if (strobe === 1'b1) seen++;
        end
        chk(seen, 2);
        // Half the unity code halves the sample under the linear volume law.
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_DAC_VOL, 1'b1, 8'h0C, q);
        dac_in = 24'h100000;
        ticks(1);
        chk(dac_out, 24'h080000);
    endtask
    task automatic pin_clear();
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_GAIN, 1'b1, 8'h07, q);
        @(negedge clk);
        pdn_n = 1'b0;
        repeat (6) @(negedge clk);
        pdn_n = 1'b1;
        repeat (3) @(negedge clk);
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_GAIN, 1'b0, 8'h00, q);
        chk(q, 8'h02);
        chk(crn, 1'b0);
        host_model_inst.xfer(1'b0, 4'h0, 1'b0, 8'h00, q);
        chk(q, 8'h30);
        host_model_inst.xfer(1'b0, 4'h0, 1'b0, 8'h00, q);
        chk(q, 8'h18);
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        defaults_burst();
        write_burst();
        wrap_read();
        host_model_inst.xfer(1'b1, codec_regs_pkg::ADDR_POWER, 1'b1, 8'h01, q);
        mute_case(8'h20, 4, 1'b1);
        mute_case(8'h30, 16, 1'b1);
        mute_case(8'h02, 4, 1'b0);
        mute_case(8'h03, 16, 1'b0);
        sample_codes();
        pin_clear();
        wrap_up();
    end
    // The run needs about 950 cycles; the limit leaves ample room.
    initial begin
        #500000;
        miscompares++;
        wrap_up();
    end
endmodule
